/* rtl/nsc_ctrl.sv */
`timescale 1ns/1ns
// Overview of operation
// - Disable auto save when no capacitor fitted.
// - Five fixed reads open every software store, recall and auto save command.
// - No other access inside the sequence.
// - Write enable stays high for six reads.
// - No access for wake delay after sleep.
// - Software store after changing auto save; the controller issues none after CMD_AUTO_OFF or CMD_AUTO_ON.
module nsc_ctrl
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output      logic        hreadyout_o,
  output      logic        hresp_o,
  output      logic [31:0] hrdata_o,
  output      logic [19:0] mem_addr_o,
  output      logic [15:0] mem_dq_o,
  output      logic        mem_dq_oe_o,
  input  wire logic [15:0] mem_dq_i,
  output      logic        first_chip_enable_n_o,
  output      logic        second_chip_enable_o,
  output      logic        output_enable_n_o,
  output      logic        write_enable_n_o,
  output      logic        upper_byte_enable_n_o,
  output      logic        lower_byte_enable_n_o,
  output      logic        sleep_request_n_o,
  output      logic        store_busy_line_o,
  output      logic        store_busy_line_oe_o,
  input  wire logic        store_busy_line_i
);

  typedef enum logic [2:0] {S_IDLE, S_ACCESS, S_HWREQ, S_SETTLE, S_WAIT_HIGH, S_RECOVER, S_WAKE} nsc_state_e;

  nsc_cycle_if cyc ();

  nsc_state_e                  state;
  logic [nsc_pkg::CNT_W-1:0]   cnt;
  logic [3:0]                  cmd;
  logic [2:0]                  step;
  logic                        inflight;
  logic                        asleep;
  logic                        done_flag;
  logic                        refused_flag;
  logic [19:0]                 addr_reg;
  logic [15:0]                 wdata_reg;
  logic [1:0]                  be_reg;
  logic [15:0]                 rdata_reg;
  logic                        wr_pend;
  logic [7:0]                  wr_addr;
  logic                        rd_pend;
  logic [7:0]                  rd_addr;
  logic                        cmd_wr;
  logic                        go_ok;
  logic                        finish;
  logic                        is_seq;
  logic [15:0]                 seq_addr;

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= '0;
      rd_addr <= '0;
    end
    else if (hready_i)
    begin
      wr_pend <= hsel_i && htrans_i == nsc_pkg::HTRANS_NONSEQ && hwrite_i;
      rd_pend <= hsel_i && htrans_i == nsc_pkg::HTRANS_NONSEQ && !hwrite_i;
      wr_addr <= haddr_i[7:0];
      rd_addr <= haddr_i[7:0];
    end
  end

  always_comb
  begin
    hrdata_o = '0;
    if (rd_pend)
    begin
      unique case (rd_addr)
        nsc_pkg::REG_CMD:    hrdata_o = {28'h0000000, cmd};
        nsc_pkg::REG_ADDR:   hrdata_o = {12'h000, addr_reg};
        nsc_pkg::REG_WDATA:  hrdata_o = {14'h0000, be_reg, wdata_reg};
        nsc_pkg::REG_RDATA:  hrdata_o = {16'h0000, rdata_reg};
        nsc_pkg::REG_STATUS: hrdata_o = {27'h0000000, refused_flag, done_flag, asleep,
                                         store_busy_line_i, state != S_IDLE};
        default:             hrdata_o = '0;
      endcase
    end
  end

  assign cmd_wr = wr_pend && wr_addr == nsc_pkg::REG_CMD;
  // Sleeping device ignores all but the sleep pin, so only wake is taken then
  assign go_ok  = state == S_IDLE &&
                  (asleep ? hwdata_i[3:0] == nsc_pkg::CMD_WAKE
                          : hwdata_i[3:0] != nsc_pkg::CMD_WAKE);

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      be_reg    <= nsc_pkg::BE_RESET;
    end
    else if (wr_pend && wr_addr == nsc_pkg::REG_ADDR)
      addr_reg <= hwdata_i[19:0];
    else if (wr_pend && wr_addr == nsc_pkg::REG_WDATA)
    begin
      wdata_reg <= hwdata_i[15:0];
      be_reg    <= hwdata_i[nsc_pkg::WDATA_BE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Status flags: completion set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      done_flag    <= 1'b0;
      refused_flag <= 1'b0;
    end
    else
    begin
      if (finish)
        done_flag <= 1'b1;
      else if (wr_pend && wr_addr == nsc_pkg::REG_STATUS && hwdata_i[nsc_pkg::ST_DONE_BIT])
        done_flag <= 1'b0;
      if (cmd_wr && !go_ok)
        refused_flag <= 1'b1;
      else if (wr_pend && wr_addr == nsc_pkg::REG_STATUS && hwdata_i[nsc_pkg::ST_REFUSED_BIT])
        refused_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      rdata_reg <= '0;
    else if (cyc.done && cmd == nsc_pkg::CMD_READ)
      rdata_reg <= cyc.rdata;
  end

  // ----------------------------------------------------------------
  // Command sequence addresses
  // ----------------------------------------------------------------
  assign is_seq = cmd == nsc_pkg::CMD_STORE || cmd == nsc_pkg::CMD_RECALL ||
                  cmd == nsc_pkg::CMD_AUTO_OFF || cmd == nsc_pkg::CMD_AUTO_ON;

  always_comb
  begin
    seq_addr = nsc_pkg::SEQ_ADDR_0;
    unique case (step)
      3'h0:    seq_addr = nsc_pkg::SEQ_ADDR_0;
      3'h1:    seq_addr = nsc_pkg::SEQ_ADDR_1;
      3'h2:    seq_addr = nsc_pkg::SEQ_ADDR_2;
      3'h3:    seq_addr = nsc_pkg::SEQ_ADDR_3;
      3'h4:    seq_addr = nsc_pkg::SEQ_ADDR_4;
      default:
      begin
        unique case (cmd)
          nsc_pkg::CMD_STORE:    seq_addr = nsc_pkg::FIN_STORE;
          nsc_pkg::CMD_RECALL:   seq_addr = nsc_pkg::FIN_RECALL;
          nsc_pkg::CMD_AUTO_OFF: seq_addr = nsc_pkg::FIN_AUTO_OFF;
          default:               seq_addr = nsc_pkg::FIN_AUTO_ON;
        endcase
      end
    endcase
  end

  // Accesses start only while the busy line is high
  assign cyc.req   = state == S_ACCESS && !inflight && store_busy_line_i;
  assign cyc.wr    = cmd == nsc_pkg::CMD_WRITE && !is_seq;
  assign cyc.addr  = is_seq ? {4'h0, seq_addr} : addr_reg;
  assign cyc.wdata = wdata_reg;
  assign cyc.be_n  = is_seq ? 2'h0 : be_reg;

  assign finish = (state == S_ACCESS && cyc.done &&
                   (!is_seq || (step == nsc_pkg::SEQ_LAST &&
                    cmd != nsc_pkg::CMD_STORE && cmd != nsc_pkg::CMD_RECALL))) ||
                  (state == S_RECOVER && cnt == '0 && store_busy_line_i) ||
                  (state == S_WAKE && cnt == '0) ||
                  (cmd_wr && go_ok && hwdata_i[3:0] == nsc_pkg::CMD_SLEEP);

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state    <= S_IDLE;
      cmd      <= nsc_pkg::CMD_READ;
      step     <= '0;
      cnt      <= '0;
      inflight <= 1'b0;
    end
    else
    begin
      if (cyc.req)
        inflight <= 1'b1;
      else if (cyc.done)
        inflight <= 1'b0;
      unique case (state)
        S_IDLE:
        begin
          step <= '0;
          if (cmd_wr && go_ok)
          begin
            cmd <= hwdata_i[3:0];
            unique case (hwdata_i[3:0])
              nsc_pkg::CMD_HW_STORE:
              begin
                state <= S_HWREQ;
                cnt   <= nsc_pkg::CNT_W'(nsc_pkg::REQ_PULSE_CYC - 1);
              end
              nsc_pkg::CMD_SLEEP:
                state <= S_IDLE;
              nsc_pkg::CMD_WAKE:
              begin
                state <= S_WAKE;
                cnt   <= nsc_pkg::CNT_W'(nsc_pkg::WAKE_CYC - 1);
              end
              default:
                state <= S_ACCESS;
            endcase
          end
        end
        S_ACCESS:
        begin
          if (cyc.done)
          begin
            if (is_seq && step != nsc_pkg::SEQ_LAST)
              step <= step + 1'b1;
            else if (cmd == nsc_pkg::CMD_STORE || cmd == nsc_pkg::CMD_RECALL)
            begin
              state <= S_SETTLE;
              cnt   <= nsc_pkg::CNT_W'(nsc_pkg::SETTLE_CYC - 1);
            end
            else
              state <= S_IDLE;
          end
        end
        S_HWREQ, S_SETTLE:
        begin
          if (cnt == '0)
            state <= S_WAIT_HIGH;
          else
            cnt <= cnt - 1'b1;
        end
        S_WAIT_HIGH:
        begin
          if (store_busy_line_i)
          begin
            state <= S_RECOVER;
            cnt   <= nsc_pkg::CNT_W'(nsc_pkg::RECOVERY_CYC - 1);
          end
        end
        S_RECOVER, S_WAKE:
        begin
          if (!store_busy_line_i && state == S_RECOVER)
            state <= S_WAIT_HIGH;
          else if (cnt == '0)
            state <= S_IDLE;
          else
            cnt <= cnt - 1'b1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sleep pin and busy line request drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      asleep <= 1'b0;
    else if (cmd_wr && go_ok && hwdata_i[3:0] == nsc_pkg::CMD_SLEEP)
      asleep <= 1'b1;
    else if (cmd_wr && go_ok && hwdata_i[3:0] == nsc_pkg::CMD_WAKE)
      asleep <= 1'b0;
  end

  assign sleep_request_n_o    = !asleep;
  assign store_busy_line_o    = 1'b0;
  assign store_busy_line_oe_o = state == S_HWREQ;

  nsc_pin_cycle u_pin_cycle
  (
    .clk_sys_i             (clk_sys_i),
    .reset_n_i             (reset_n_i),
    .cyc                   (cyc.engine),
    .mem_addr_o            (mem_addr_o),
    .mem_dq_o              (mem_dq_o),
    .mem_dq_oe_o           (mem_dq_oe_o),
    .mem_dq_i              (mem_dq_i),
    .first_chip_enable_n_o (first_chip_enable_n_o),
    .second_chip_enable_o  (second_chip_enable_o),
    .output_enable_n_o     (output_enable_n_o),
    .write_enable_n_o      (write_enable_n_o),
    .upper_byte_enable_n_o (upper_byte_enable_n_o),
    .lower_byte_enable_n_o (lower_byte_enable_n_o)
  );

endmodule : nsc_ctrl

/* rtl/nsc_pkg.sv */
package nsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned ACCESS_NS      = 45;
  localparam int unsigned ACCESS_CYC     = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RECOVERY_NS    = 20;
  localparam int unsigned RECOVERY_CYC   = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REQ_PULSE_NS   = 100;
  localparam int unsigned REQ_PULSE_CYC  = (REQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_NS      = 100;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_NS        = 8000;
  localparam int unsigned WAKE_CYC       = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W          = 12;

  // ----------------------------------------------------------------
  // Memory port widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // Command sequence addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQ_ADDR_0    = 16'h4e38;
  localparam logic [15:0] SEQ_ADDR_1    = 16'hb1c7;
  localparam logic [15:0] SEQ_ADDR_2    = 16'h83e0;
  localparam logic [15:0] SEQ_ADDR_3    = 16'h7c1f;
  localparam logic [15:0] SEQ_ADDR_4    = 16'h703f;
  localparam logic [15:0] FIN_STORE     = 16'h8fc0;
  localparam logic [15:0] FIN_RECALL    = 16'h4c63;
  localparam logic [15:0] FIN_AUTO_OFF  = 16'h8b45;
  localparam logic [15:0] FIN_AUTO_ON   = 16'h4b46;
  localparam logic [2:0]  SEQ_LAST      = 3'h5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int unsigned CMD_CODE_LSB   = 0;
  localparam int unsigned WDATA_BE_LSB   = 16;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_LINE_BIT    = 1;
  localparam int unsigned ST_SLEEP_BIT   = 2;
  localparam int unsigned ST_DONE_BIT    = 3;
  localparam int unsigned ST_REFUSED_BIT = 4;

  localparam logic [1:0] BE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Commands written to the command register
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_READ     = 4'h0;
  localparam logic [3:0] CMD_WRITE    = 4'h1;
  localparam logic [3:0] CMD_STORE    = 4'h2;
  localparam logic [3:0] CMD_RECALL   = 4'h3;
  localparam logic [3:0] CMD_AUTO_OFF = 4'h4;
  localparam logic [3:0] CMD_AUTO_ON  = 4'h5;
  localparam logic [3:0] CMD_HW_STORE = 4'h6;
  localparam logic [3:0] CMD_SLEEP    = 4'h7;
  localparam logic [3:0] CMD_WAKE     = 4'h8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : nsc_pkg

/* rtl/nsc_cycle_if.sv */
`timescale 1ns/1ns
interface nsc_cycle_if;
  logic        req;
  logic        wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [1:0]  be_n;
  logic        done;
  logic [15:0] rdata;

  modport ctrl   (output req, output wr, output addr, output wdata, output be_n, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, input be_n, output done, output rdata);
endinterface : nsc_cycle_if

/* rtl/nsc_pin_cycle.sv */
`timescale 1ns/1ns
module nsc_pin_cycle
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  nsc_cycle_if.engine      cyc,
  output      logic [19:0] mem_addr_o,
  output      logic [15:0] mem_dq_o,
  output      logic        mem_dq_oe_o,
  input  wire logic [15:0] mem_dq_i,
  output      logic        first_chip_enable_n_o,
  output      logic        second_chip_enable_o,
  output      logic        output_enable_n_o,
  output      logic        write_enable_n_o,
  output      logic        upper_byte_enable_n_o,
  output      logic        lower_byte_enable_n_o
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} nsc_eng_e;

  nsc_eng_e                      state;
  logic [nsc_pkg::CNT_W-1:0]     cnt;
  logic                          wr_q;

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state <= E_IDLE;
      cnt   <= '0;
      wr_q  <= 1'b0;
    end
    else
    begin
      unique case (state)
        E_IDLE:
        begin
          if (cyc.req)
          begin
            state <= E_SETUP;
            wr_q  <= cyc.wr;
          end
        end
        E_SETUP:
        begin
          state <= E_STROBE;
          cnt   <= nsc_pkg::CNT_W'(nsc_pkg::ACCESS_CYC - 1);
        end
        E_STROBE:
        begin
          if (cnt == '0)
            state <= E_HOLD;
          else
            cnt <= cnt - 1'b1;
        end
        E_HOLD:
          state <= E_IDLE;
      endcase
    end
  end

  assign cyc.done = (state == E_HOLD);

  // ----------------------------------------------------------------
  // Pin drive; deselected means first enable high, second low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      mem_addr_o            <= '0;
      mem_dq_o              <= '0;
      mem_dq_oe_o           <= 1'b0;
      first_chip_enable_n_o <= 1'b1;
      second_chip_enable_o  <= 1'b0;
      output_enable_n_o     <= 1'b1;
      write_enable_n_o      <= 1'b1;
      upper_byte_enable_n_o <= 1'b1;
      lower_byte_enable_n_o <= 1'b1;
    end
    else
    begin
      if (state == E_IDLE && cyc.req)
      begin
        mem_addr_o            <= cyc.addr;
        mem_dq_o              <= cyc.wdata;
        mem_dq_oe_o           <= cyc.wr;
        upper_byte_enable_n_o <= cyc.be_n[1];
        lower_byte_enable_n_o <= cyc.be_n[0];
        first_chip_enable_n_o <= 1'b0;
        second_chip_enable_o  <= 1'b1;
      end
      else if (state == E_SETUP)
      begin
        output_enable_n_o <= wr_q;
        write_enable_n_o  <= !wr_q;
      end
      else if (state == E_STROBE && cnt == '0)
      begin
        output_enable_n_o     <= 1'b1;
        write_enable_n_o      <= 1'b1;
        first_chip_enable_n_o <= 1'b1;
        second_chip_enable_o  <= 1'b0;
      end
      else if (state == E_HOLD)
      begin
        mem_dq_oe_o           <= 1'b0;
        upper_byte_enable_n_o <= 1'b1;
        lower_byte_enable_n_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      cyc.rdata <= '0;
    else if (state == E_STROBE && cnt == '0 && !wr_q)
      cyc.rdata <= mem_dq_i;
  end

endmodule : nsc_pin_cycle

/* tb/nsc_chk.sv */
`timescale 1ns/1ns
module nsc_chk
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic [19:0] mem_addr_o,
  input wire logic        mem_dq_oe_o,
  input wire logic        first_chip_enable_n_o,
  input wire logic        second_chip_enable_o,
  input wire logic        output_enable_n_o,
  input wire logic        write_enable_n_o,
  input wire logic        sleep_request_n_o,
  input wire logic        store_busy_line_o,
  input wire logic        store_busy_line_oe_o,
  input wire logic        store_busy_line_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [11:0] wake_cnt;

  // --------------------------------------------
  // Cycles since the sleep request went high
  // --------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      wake_cnt <= 12'hfff;
    else if (!sleep_request_n_o)
      wake_cnt <= 12'h0;
    else if (wake_cnt != 12'hfff)
      wake_cnt <= wake_cnt + 12'h1;
  end

  chk_chip_pair: assert property (first_chip_enable_n_o == !second_chip_enable_o)
    else $error("chip enables disagree");
  chk_strobe_sel: assert property (!output_enable_n_o || !write_enable_n_o |->
    !first_chip_enable_n_o && (output_enable_n_o ^ write_enable_n_o)) else $error("bad strobe");
  chk_read_len: assert property ($fell(output_enable_n_o) |->
    write_enable_n_o [*8] ##4 !output_enable_n_o ##1 output_enable_n_o) else $error("read length");
  chk_write_len: assert property ($fell(write_enable_n_o) |->
    mem_dq_oe_o [*8] ##5 write_enable_n_o && mem_dq_oe_o ##1 !mem_dq_oe_o) else $error("write length");
  chk_start_line: assert property ($fell(first_chip_enable_n_o) |-> $past(store_busy_line_i))
    else $error("access while line low");
  chk_addr_hold: assert property (!first_chip_enable_n_o && !$fell(first_chip_enable_n_o) |->
    $stable(mem_addr_o)) else $error("address moved");
  chk_busy_pulse: assert property ($rose(store_busy_line_oe_o) |->
    (store_busy_line_oe_o && !store_busy_line_o) [*8]) else $error("short request");
  chk_sleep_quiet: assert property (!sleep_request_n_o |->
    first_chip_enable_n_o && !store_busy_line_oe_o) else $error("active in sleep");
  chk_wake_wait: assert property (wake_cnt < nsc_pkg::WAKE_CYC |-> first_chip_enable_n_o)
    else $error("access before wake");
endmodule : nsc_chk

bind nsc_ctrl nsc_chk i_chk (.clk_sys_i, .reset_n_i, .mem_addr_o, .mem_dq_oe_o, .first_chip_enable_n_o,
  .second_chip_enable_o, .output_enable_n_o, .write_enable_n_o, .sleep_request_n_o, .store_busy_line_o,
  .store_busy_line_oe_o, .store_busy_line_i);

/* tb/nsc_dev_model.sv */
`timescale 1ns/1ns
module nsc_dev_model
#(
  parameter int STORE_CYC = 40
)
(
  input  wire logic        clk_sys_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  output      logic [15:0] dq_o,
  input  wire logic        first_chip_enable_n_i,
  input  wire logic        second_chip_enable_i,
  input  wire logic        output_enable_n_i,
  input  wire logic        write_enable_n_i,
  input  wire logic        upper_byte_enable_n_i,
  input  wire logic        lower_byte_enable_n_i,
  input  wire logic        sleep_request_n_i,
  input  wire logic        store_busy_line_i,
  output      logic        pull_o
);
  logic [15:0] mem [0:255];
  logic [15:0] nv [0:255];
  logic [15:0] seq_tab [0:4] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
  logic [15:0] last = 16'h0;
  logic [1:0]  be_q;
  logic [2:0]  seq = 3'h0;
  logic        cs;
  logic        cs_q = 1'b0;
  logic        we_q;
  logic        zz_q = 1'b1;
  logic        wl = 1'b0;
  logic        auto_en = 1'b1;
  int          busy = 0;
  int          stores = 0;
  int          recalls = 0;

  function automatic logic hit(input logic [15:0] a);
    return addr_i[14:2] == a[14:2];
  endfunction : hit

  task nv_store;
    busy <= STORE_CYC;
    stores++;
    wl <= 1'b0;
    for (int i = 0; i < 256; i++) nv[i] <= mem[i];
  endtask : nv_store

  assign cs = !first_chip_enable_n_i && second_chip_enable_i;
  assign pull_o = busy != 0;
  // Unread bus shows a changing pattern, never the last value
  assign dq_o = cs && !output_enable_n_i && write_enable_n_i && sleep_request_n_i && store_busy_line_i
    && !pull_o ? mem[addr_i[7:0]] : ~last;
  initial
  begin
    for (int i = 0; i < 256; i++) nv[i] = 16'h0;
    for (int i = 0; i < 256; i++) mem[i] = nv[i];
  end

  always @(posedge clk_sys_i)
  begin
    last <= dq_o;
    cs_q <= cs && !pull_o;
    we_q <= write_enable_n_i;
    be_q <= {upper_byte_enable_n_i, lower_byte_enable_n_i};
    zz_q <= sleep_request_n_i;
    if (pull_o)
      busy <= busy - 1;
    if (zz_q && !sleep_request_n_i)
      nv_store();
    else if (!store_busy_line_i && !pull_o && wl)
      nv_store();
    else if (cs_q && !cs && sleep_request_n_i)
    begin
      if (!we_q)
      begin
        if (!be_q[0] && store_busy_line_i) mem[addr_i[7:0]][7:0] <= dq_i[7:0];
        if (!be_q[1] && store_busy_line_i) mem[addr_i[7:0]][15:8] <= dq_i[15:8];
        wl <= 1'b1;
        seq <= 3'h0;
      end
      else if (seq == 3'h5)
      begin
        if (hit(16'h8fc0)) nv_store();
        if (hit(16'h4c63))
        begin
          recalls++;
          wl <= 1'b0;
          busy <= STORE_CYC;
          for (int i = 0; i < 256; i++) mem[i] <= nv[i];
        end
        if (hit(16'h8b45)) auto_en <= 1'b0;
        if (hit(16'h4b46)) auto_en <= 1'b1;
        seq <= 3'h0;
      end
      else
        seq <= hit(seq_tab[seq]) ? seq + 3'h1 : {2'h0, hit(seq_tab[0])};
    end
  end
endmodule : nsc_dev_model

/* tb/nvram_store_recall_control_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module nvram_store_recall_control_tb;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rd;
  logic [19:0] mem_addr_o;
  logic [15:0] mem_dq_o, mem_dq_i;
  logic        hreadyout_o, hresp_o, mem_dq_oe_o, first_chip_enable_n_o, second_chip_enable_o;
  logic        output_enable_n_o, write_enable_n_o, upper_byte_enable_n_o, lower_byte_enable_n_o;
  logic        sleep_request_n_o, store_busy_line_o, store_busy_line_oe_o, store_busy_line_i, dev_pull;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #2 clk_sys_i = ~clk_sys_i;
  // Open-drain busy line with pull-up
  assign store_busy_line_i = !(store_busy_line_oe_o && !store_busy_line_o) && !dev_pull;

  nsc_ctrl i_dut (.clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .mem_addr_o, .mem_dq_o, .mem_dq_oe_o, .mem_dq_i,
    .first_chip_enable_n_o, .second_chip_enable_o, .output_enable_n_o, .write_enable_n_o, .upper_byte_enable_n_o,
    .lower_byte_enable_n_o, .sleep_request_n_o, .store_busy_line_o, .store_busy_line_oe_o, .store_busy_line_i);

  nsc_dev_model i_dev (.clk_sys_i, .addr_i(mem_addr_o), .dq_i(mem_dq_o), .dq_o(mem_dq_i),
    .first_chip_enable_n_i(first_chip_enable_n_o), .second_chip_enable_i(second_chip_enable_o),
    .output_enable_n_i(output_enable_n_o), .write_enable_n_i(write_enable_n_o),
    .upper_byte_enable_n_i(upper_byte_enable_n_o), .lower_byte_enable_n_i(lower_byte_enable_n_o),
    .sleep_request_n_i(sleep_request_n_o), .store_busy_line_i, .pull_o(dev_pull));

  task finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= nsc_pkg::HTRANS_NONSEQ;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    hsize_i  <= 3'h2;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus

  // Issue a command, wait for idle, check and clear the done flag
  task automatic cmd(input logic [3:0] c);
    int n;
    bus(1'b1, 8'h00, {28'h0, c});
    n = 0;
    do
    begin
      bus(1'b0, 8'h10, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 3000);
    `CHK("done", 1'b1, rd[3])
    bus(1'b1, 8'h10, 32'h18);
  endtask : cmd

  task automatic t_reset;
    `CHK("ce1_n", 1'b1, first_chip_enable_n_o)
    bus(1'b0, 8'h10, 32'h0);
    `CHK("status", 32'h2, rd)
    `CHK("hresp", 1'b0, hresp_o)
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset

  task automatic t_clean;
    cmd(4'h6);
    `CHK("hw_skip", 0, i_dev.stores)
    cmd(4'h2);
    `CHK("sw_store", 1, i_dev.stores)
  endtask : t_clean

  task automatic t_rw;
    bus(1'b1, 8'h04, 32'h12);
    bus(1'b1, 8'h08, 32'ha55a);
    cmd(4'h1);
    bus(1'b1, 8'h08, 32'h21234);
    cmd(4'h1);
    cmd(4'h0);
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("bytes", 16'ha534, rd[15:0])
  endtask : t_rw

  task automatic t_nv;
    cmd(4'h6);
    `CHK("hw_store", 2, i_dev.stores)
    bus(1'b1, 8'h08, 32'h5555);
    cmd(4'h1);
    cmd(4'h3);
    `CHK("recalls", 1, i_dev.recalls)
    cmd(4'h0);
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("recalled", 16'ha534, rd[15:0])
    cmd(4'h4);
    `CHK("auto_off", 1'b0, i_dev.auto_en)
    cmd(4'h5);
    `CHK("auto_on", 1'b1, i_dev.auto_en)
  endtask : t_nv

  task automatic t_sleep;
    bus(1'b1, 8'h00, 32'h8);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("refused", 1'b1, rd[4])
    bus(1'b1, 8'h10, 32'h10);
    cmd(4'h7);
    `CHK("zz", 1'b0, sleep_request_n_o)
    `CHK("sleep_store", 3, i_dev.stores)
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("asleep", 2'h3, {rd[4], rd[2]})
    cmd(4'h8);
    `CHK("awake", 1'b1, sleep_request_n_o)
  endtask : t_sleep

  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_clean();
    t_rw();
    t_nv();
    t_sleep();
    finish_test();
  end
endmodule : nvram_store_recall_control_tb
